// ===== pkg/deser_mode_cfg.svh
// Constants for the deserializer output mode and control block
// Overview of operation
// - Width select high gives 20-bit words
// - Width select low gives 10-bit words
// - Standard mode, not ASI: upper lane chroma
// - Both low: upper lane data-through
// - 10-bit output: upper lane forced low
// - SD 20-bit ASI: upper lane held low
// - Master enable high enables the corrections allowed at the current rate
// - Disable register bits turn features off
// - Master enable low disables all processing
// - Mode pin driven auto, input manual
// - Auto: mode pin high only when locked
// - Manual, mode high, no ASI: standard mode
// - Manual mode low: no descramble or processing
// - Host reset: defaults, all outputs high impedance
// - Test-port reset: defaults, test sequence held
// - Rate low HD, high SD; auto drives
// - Auto select high drives bidirectional pins
// - ASI select low: no ASI decoding
`ifndef DESER_MODE_CFG_SVH
`define DESER_MODE_CFG_SVH
`define ADDR_DISABLE 4'h0
`define ADDR_STATUS 4'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FEAT_COUNT 6
`define FEAT_RESET 6'h00
`define FEAT_SD_ONLY 6'h01
`define FEAT_HD_ONLY 6'h0c
`define SYNC_COUNT 8
`define SYNC_RESET 8'h80
`define SY_WIDTH 0
`define SY_MASTER 1
`define SY_AUTO 2
`define SY_ASI 3
`define SY_STD 4
`define SY_RATE 5
`define SY_TEST 6
`define SY_RST_N 7
`define ST_WIDTH 0
`define ST_MASTER 1
`define ST_AUTO 2
`define ST_ASI 3
`define ST_STD 4
`define ST_RATE 5
`define ST_TEST 6
`define ST_RESET 7
`define ST_FEAT_LO 8
`define ST_FEAT_HI 13
`define STATUS_PAD 18'h00000
`define DISABLE_PAD 26'h0000000
`endif

// ===== pkg/deser_mode_pkg.sv
// Types for the deserializer output mode and control block
package deser_mode_pkg;
   typedef enum logic [1:0] {
      DEV_HELD = 2'h0,
      DEV_WAKE = 2'h1,
      DEV_RUN = 2'h3
   } dev_state_t;
   typedef enum logic [1:0] {
      HIT_NONE = 2'h0,
      HIT_DISABLE = 2'h1,
      HIT_STATUS = 2'h2
   } reg_hit_t;
endpackage

// ===== rtl/mode_sync.sv
// Two-stage synchroniser for asynchronous mode pins
module mode_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   // First stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule

// ===== rtl/deser_output_mode_control.sv
// Output format, processing gating and mode pin control with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "deser_mode_cfg.svh"
module deser_output_mode_control
   import deser_mode_pkg::*;
#(
   parameter int ADDR_W = 4,
   parameter int WORD_W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bus_width_select,
   input wire logic processing_master_enable,
   input wire logic auto_manual_select,
   input wire logic asi_mode_select,
   input wire logic standard_mode_pin_in,
   output logic standard_mode_pin_out,
   output logic standard_mode_pin_oe_n,
   input wire logic rate_select_in,
   output logic rate_select_out,
   output logic rate_select_oe_n,
   input wire logic device_reset_pin_n,
   input wire logic test_port_mode,
   input wire logic core_smpte_locked,
   input wire logic core_rate_sd,
   input wire logic [WORD_W-1:0] luma_word,
   input wire logic [WORD_W-1:0] chroma_word,
   input wire logic [WORD_W-1:0] through_word,
   input wire logic [WORD_W-1:0] mux_word,
   output logic [WORD_W-1:0] dout_upper,
   output logic [WORD_W-1:0] dout_lower,
   output logic dout_oe_n,
   output logic loop_serial_out_oe_n,
   output logic [`FEAT_COUNT-1:0] feature_enable,
   output logic descramble_enable,
   output logic word_align_enable,
   output logic asi_decode_enable,
   output logic test_sequence_reset,
   output logic device_in_reset
);

   // Address decode shared by both channels
   function automatic reg_hit_t decode_addr(input logic [ADDR_W-1:0] addr);
      reg_hit_t hit;
      hit = HIT_NONE;
      if (addr == ADDR_W'(`ADDR_DISABLE)) begin
         hit = HIT_DISABLE;
      end else if (addr == ADDR_W'(`ADDR_STATUS)) begin
         hit = HIT_STATUS;
      end
      return hit;
   endfunction

   logic [`SYNC_COUNT-1:0] pins_async;
   logic [`SYNC_COUNT-1:0] pins_sync;
   dev_state_t state_reg;
   dev_state_t state_next;
   logic in_reset;
   logic pins_hiz;
   logic width_20;
   logic master_en;
   logic auto_cfg;
   logic asi_sel;
   logic test_mode;
   logic std_mode;
   logic rate_sd;
   logic smpte_mode;
   logic proc_allowed;
   logic [`FEAT_COUNT-1:0] rate_ok;
   logic [`FEAT_COUNT-1:0] feat_next;
   logic [WORD_W-1:0] upper_next;
   logic [WORD_W-1:0] lower_next;
   logic [`FEAT_COUNT-1:0] disable_reg;
   logic [`FEAT_COUNT-1:0] feat_reg;
   logic [WORD_W-1:0] upper_reg;
   logic [WORD_W-1:0] lower_reg;
   logic dout_oe_n_reg;
   logic loop_oe_n_reg;
   logic std_out_reg;
   logic rate_out_reg;
   logic pin_oe_n_reg;
   logic descr_reg;
   logic align_reg;
   logic asi_dec_reg;
   logic test_rst_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [`FEAT_COUNT-1:0] wdata_reg;
   logic wstrb0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic commit;
   reg_hit_t wr_hit;
   reg_hit_t rd_hit;
   logic [31:0] status_word;
   logic [31:0] disable_word;
   logic [31:0] read_word;

   // Asynchronous pins into the clock domain
   assign pins_async[`SY_WIDTH] = bus_width_select;
   assign pins_async[`SY_MASTER] = processing_master_enable;
   assign pins_async[`SY_AUTO] = auto_manual_select;
   assign pins_async[`SY_ASI] = asi_mode_select;
   assign pins_async[`SY_STD] = standard_mode_pin_in;
   assign pins_async[`SY_RATE] = rate_select_in;
   assign pins_async[`SY_TEST] = test_port_mode;
   assign pins_async[`SY_RST_N] = device_reset_pin_n;

   mode_sync #(
      .WIDTH(`SYNC_COUNT),
      .RESET_VAL(`SYNC_RESET)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   // Device reset pin sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DEV_HELD: begin
            if (pins_sync[`SY_RST_N]) begin
               state_next = DEV_WAKE;
            end
         end
         DEV_WAKE: begin
            state_next = pins_sync[`SY_RST_N] ? DEV_RUN : DEV_HELD;
         end
         DEV_RUN: begin
            if (!pins_sync[`SY_RST_N]) begin
               state_next = DEV_HELD;
            end
         end
         default: begin
            state_next = DEV_HELD;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= DEV_HELD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign in_reset = (state_reg != DEV_RUN);
   assign test_mode = pins_sync[`SY_TEST];
   assign pins_hiz = in_reset & ~test_mode;

   // Effective modes
   assign width_20 = pins_sync[`SY_WIDTH];
   assign master_en = pins_sync[`SY_MASTER];
   assign auto_cfg = pins_sync[`SY_AUTO];
   assign asi_sel = pins_sync[`SY_ASI];
   assign std_mode = auto_cfg ? core_smpte_locked : pins_sync[`SY_STD];
   assign rate_sd = auto_cfg ? core_rate_sd : pins_sync[`SY_RATE];
   assign smpte_mode = std_mode & ~asi_sel;
   assign proc_allowed = master_en & smpte_mode & ~in_reset;

   // Per-feature gating by master enable, disable bits and rate
   genvar gi;
   generate
      for (gi = 0; gi < `FEAT_COUNT; gi++) begin : g_feat
         localparam logic [`FEAT_COUNT-1:0] SDM = `FEAT_SD_ONLY;
         localparam logic [`FEAT_COUNT-1:0] HDM = `FEAT_HD_ONLY;
         assign rate_ok[gi] = (SDM[gi] ? rate_sd : 1'b1) & (HDM[gi] ? ~rate_sd : 1'b1);
         assign feat_next[gi] = proc_allowed & rate_ok[gi] & ~disable_reg[gi];
      end
   endgenerate

   // Parallel word formatting
   assign lower_next = in_reset ? '0 : (width_20 ? luma_word : mux_word);
   always_comb begin
      upper_next = '0;
      if (in_reset || !width_20) begin
         upper_next = '0;
      end else if (smpte_mode) begin
         upper_next = chroma_word;
      end else if (!std_mode && !asi_sel) begin
         upper_next = through_word;
      end else begin
         upper_next = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upper_reg <= '0;
         lower_reg <= '0;
         feat_reg <= `FEAT_RESET;
         dout_oe_n_reg <= 1'b1;
         loop_oe_n_reg <= 1'b1;
      end else begin
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         feat_reg <= feat_next;
         dout_oe_n_reg <= pins_hiz;
         loop_oe_n_reg <= pins_hiz;
      end
   end

   // Bidirectional mode pins and datapath enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         std_out_reg <= 1'b0;
         rate_out_reg <= 1'b0;
         pin_oe_n_reg <= 1'b1;
         descr_reg <= 1'b0;
         align_reg <= 1'b0;
         asi_dec_reg <= 1'b0;
         test_rst_reg <= 1'b0;
      end else begin
         std_out_reg <= core_smpte_locked;
         rate_out_reg <= core_rate_sd;
         pin_oe_n_reg <= ~auto_cfg | pins_hiz;
         descr_reg <= smpte_mode & ~in_reset;
         align_reg <= (smpte_mode | asi_sel) & ~in_reset;
         asi_dec_reg <= asi_sel & ~in_reset;
         test_rst_reg <= in_reset & test_mode;
      end
   end

   // AXI4-Lite write channel
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign commit = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_hit = decode_addr(awaddr_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[`FEAT_COUNT-1:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (commit) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_hit == HIT_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Feature disable register, cleared while the device is held in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disable_reg <= `FEAT_RESET;
      end else if (in_reset) begin
         disable_reg <= `FEAT_RESET;
      end else if (commit && wr_hit == HIT_DISABLE && wstrb0_reg) begin
         disable_reg <= wdata_reg;
      end
   end

   // AXI4-Lite read channel
   assign s_axi_arready = ~rvalid_reg;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign rd_hit = decode_addr(s_axi_araddr);
   assign disable_word = {`DISABLE_PAD, disable_reg};
   assign status_word = {`STATUS_PAD, feat_reg, in_reset, test_mode, rate_sd, std_mode,
                         asi_sel, auto_cfg, master_en, width_20};
   assign read_word = (rd_hit == HIT_DISABLE) ? disable_word :
                      (rd_hit == HIT_STATUS) ? status_word : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= read_word;
         rresp_reg <= (rd_hit == HIT_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Outputs
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign dout_upper = upper_reg;
   assign dout_lower = lower_reg;
   assign dout_oe_n = dout_oe_n_reg;
   assign loop_serial_out_oe_n = loop_oe_n_reg;
   assign feature_enable = feat_reg;
   assign standard_mode_pin_out = std_out_reg;
   assign rate_select_out = rate_out_reg;
   assign standard_mode_pin_oe_n = pin_oe_n_reg;
   assign rate_select_oe_n = pin_oe_n_reg;
   assign descramble_enable = descr_reg;
   assign word_align_enable = align_reg;
   assign asi_decode_enable = asi_dec_reg;
   assign test_sequence_reset = test_rst_reg;
   assign device_in_reset = in_reset;

endmodule

// ===== verification/deser_output_mode_control_checker.sv
// Concurrent checks on the ports of the output mode and control block
`include "deser_mode_cfg.svh"
module deser_output_mode_control_checker #(
   parameter int ADDR_W = 4,
   parameter int WORD_W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_width_select,
   input wire logic processing_master_enable,
   input wire logic auto_manual_select,
   input wire logic asi_mode_select,
   input wire logic standard_mode_pin_in,
   input wire logic device_reset_pin_n,
   input wire logic test_port_mode,
   input wire logic core_smpte_locked,
   input wire logic [WORD_W-1:0] luma_word,
   input wire logic [WORD_W-1:0] dout_upper,
   input wire logic [WORD_W-1:0] dout_lower,
   input wire logic dout_oe_n,
   input wire logic loop_serial_out_oe_n,
   input wire logic standard_mode_pin_out,
   input wire logic standard_mode_pin_oe_n,
   input wire logic [`FEAT_COUNT-1:0] feature_enable,
   input wire logic descramble_enable,
   input wire logic asi_decode_enable,
   input wire logic test_sequence_reset,
   input wire logic device_in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_wide_lower_luma: assert property (
      (bus_width_select && !device_in_reset) [*4] |=> dout_lower == $past(luma_word)) else $error("lower not luma");
   chk_narrow_upper_low: assert property (
      (!bus_width_select) [*4] |=> dout_upper == '0) else $error("upper not low");
   chk_master_off_all: assert property (
      (!processing_master_enable) [*4] |=> feature_enable == '0) else $error("feature on");
   chk_manual_pin_input: assert property (
      (!auto_manual_select) [*4] |=> standard_mode_pin_oe_n) else $error("pin driven");
   chk_auto_pin_lock: assert property (
      !standard_mode_pin_oe_n |-> standard_mode_pin_out == $past(core_smpte_locked)) else $error("pin not lock");
   chk_manual_bypass_off: assert property (
      (!auto_manual_select && !standard_mode_pin_in && !asi_mode_select) [*4]
      |=> !descramble_enable && feature_enable == '0) else $error("bypass active");
   chk_host_reset_hiz: assert property (
      (!device_reset_pin_n && !test_port_mode) [*6]
      |=> dout_oe_n && loop_serial_out_oe_n && standard_mode_pin_oe_n) else $error("not hiz");
   chk_test_reset_hold: assert property (
      (!device_reset_pin_n && test_port_mode) [*6] |=> test_sequence_reset && device_in_reset) else $error("no hold");
   chk_test_reset_free: assert property (
      (device_reset_pin_n && test_port_mode) [*6] |=> !test_sequence_reset) else $error("still held");
   chk_asi_decode_off: assert property (
      (!asi_mode_select) [*4] |=> !asi_decode_enable) else $error("asi decode on");
   cov_chroma: cover property (bus_width_select && standard_mode_pin_in && dout_upper != '0);
   cov_hiz: cover property (dout_oe_n && standard_mode_pin_oe_n);
   cov_auto_drive: cover property (!standard_mode_pin_oe_n && standard_mode_pin_out);
endmodule
bind deser_output_mode_control deser_output_mode_control_checker #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) chk (
   .aclk, .aresetn, .bus_width_select, .processing_master_enable, .auto_manual_select, .asi_mode_select,
   .standard_mode_pin_in, .device_reset_pin_n, .test_port_mode, .core_smpte_locked, .luma_word, .dout_upper,
   .dout_lower, .dout_oe_n, .loop_serial_out_oe_n, .standard_mode_pin_out, .standard_mode_pin_oe_n,
   .feature_enable, .descramble_enable, .asi_decode_enable, .test_sequence_reset, .device_in_reset);

// ===== verification/video_sink.sv
// Downstream video sink capturing the parallel words
module video_sink #(
   parameter int WORD_W = 10
) (
   input wire logic aclk,
   input wire logic [WORD_W-1:0] dout_upper,
   input wire logic [WORD_W-1:0] dout_lower,
   input wire logic dout_oe_n,
   output logic [WORD_W-1:0] cap_upper,
   output logic [WORD_W-1:0] cap_lower
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released bus shows the last word and its inverse in alternate cycles
   always_ff @(posedge aclk) begin
      cap_upper <= dout_oe_n ? ~cap_upper : dout_upper;
      cap_lower <= dout_oe_n ? ~cap_lower : dout_lower;
   end
endmodule

// ===== verification/test_deser_output_mode_control.sv
// Self-checking testbench for the output mode and control block
module test_deser_output_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, probe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rate_select_in;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic bus_width_select, processing_master_enable, auto_manual_select, asi_mode_select, standard_mode_pin_in;
   logic standard_mode_pin_out, standard_mode_pin_oe_n, rate_select_out, rate_select_oe_n, device_reset_pin_n;
   logic test_port_mode, core_smpte_locked, core_rate_sd, dout_oe_n, loop_serial_out_oe_n, descramble_enable;
   logic word_align_enable, asi_decode_enable, test_sequence_reset, device_in_reset;
   logic [9:0] luma_word, chroma_word, through_word, mux_word, dout_upper, dout_lower, cap_upper, cap_lower;
   logic [5:0] feature_enable, dis;
   logic [34:0] got, e;
   logic [1:0] qb[$];
   logic [33:0] qr[$];
   logic [34:0] qo[$];
   int num_errors = 0;
   int num_checks = 0;
   deser_output_mode_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .bus_width_select, .processing_master_enable, .auto_manual_select, .asi_mode_select,
      .standard_mode_pin_in, .standard_mode_pin_out, .standard_mode_pin_oe_n, .rate_select_in, .rate_select_out,
      .rate_select_oe_n, .device_reset_pin_n, .test_port_mode, .core_smpte_locked, .core_rate_sd, .luma_word,
      .chroma_word, .through_word, .mux_word, .dout_upper, .dout_lower, .dout_oe_n, .loop_serial_out_oe_n,
      .feature_enable, .descramble_enable, .word_align_enable, .asi_decode_enable, .test_sequence_reset,
      .device_in_reset);
   video_sink snk (.aclk, .dout_upper, .dout_lower, .dout_oe_n, .cap_upper, .cap_lower);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_resp(input logic [1:0] g, input logic [1:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: bresp %h expected %h", $time, g, x);
      end
   endtask
   task automatic cmp_read(input logic [33:0] g, input logic [33:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: read %h expected %h", $time, g, x);
      end
   endtask
   task automatic cmp_out(input logic [34:0] g, input logic [34:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: outputs %h expected %h", $time, g, x);
      end
   endtask
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ha, hw, hb;
      qb.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid && s_axi_bready;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end
   endtask
   task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ha, hr;
      qr.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge aclk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid && s_axi_rready;
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
      end
   endtask
   task automatic expect_out(input bit hiz, input bit rst);
      logic s, r, act;
      logic [9:0] up, lo;
      logic [5:0] fe;
      repeat (6) @(posedge aclk);
      s = auto_manual_select ? core_smpte_locked : standard_mode_pin_in;
      r = auto_manual_select ? core_rate_sd : rate_select_in;
      act = !rst;
      up = (!act || !bus_width_select || asi_mode_select) ? 10'h000 : (s ? chroma_word : through_word);
      lo = !act ? 10'h000 : (bus_width_select ? luma_word : mux_word);
      fe = (act && processing_master_enable && s && !asi_mode_select) ? ((r ? 6'h33 : 6'h3e) & ~dis) : 6'h00;
      qo.push_back({(s || asi_mode_select) && act, !(auto_manual_select && !hiz),
         test_port_mode && rst, core_rate_sd, core_smpte_locked, !(auto_manual_select && !hiz), hiz,
         fe, s && !asi_mode_select && act, asi_mode_select && act, up, lo});
      probe <= 1'b1;
      @(posedge aclk);
      probe <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) cmp_resp(s_axi_bresp, qb.pop_front());
      if (s_axi_rvalid && s_axi_rready) cmp_read({s_axi_rresp, s_axi_rdata}, qr.pop_front());
      if (probe) begin
         got = {word_align_enable, rate_select_oe_n, test_sequence_reset, rate_select_out, standard_mode_pin_out,
            standard_mode_pin_oe_n, dout_oe_n, feature_enable, descramble_enable, asi_decode_enable, cap_upper,
            cap_lower};
         e = qo.pop_front();
         if (e[28]) got[19:0] = e[19:0];
         cmp_out(got, e);
      end
   end
   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      print_verdict();
   end
   initial begin
      {aresetn, probe, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {bus_width_select, processing_master_enable, auto_manual_select, asi_mode_select} = 4'hc;
      {standard_mode_pin_in, rate_select_in, test_port_mode, core_smpte_locked, core_rate_sd} = 5'h10;
      {luma_word, chroma_word, through_word, mux_word} = '0;
      device_reset_pin_n = 1'b1;
      seed = 32'h0b1a;
      dis = 6'h00;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         rate_select_in <= r[0];
         device_reset_pin_n <= 1'b0;
         repeat (4) @(posedge aclk);
         device_reset_pin_n <= 1'b1;
         repeat (8) @(posedge aclk);
         axi_read(4'h0, 32'h0, 2'h0);
         dis = r ? 6'h00 : 6'h12;
         axi_write(4'h0, {26'h3ffffff, dis}, 2'h0);
         axi_read(4'h0, {26'h0, dis}, 2'h0);
         for (int i = 0; i < 16; i++) begin
            {bus_width_select, processing_master_enable, standard_mode_pin_in, asi_mode_select} <= i[3:0];
            seed = lfsr(seed);
            luma_word <= seed[9:0];
            chroma_word <= seed[19:10];
            through_word <= seed[29:20];
            seed = lfsr(seed);
            mux_word <= seed[9:0];
            expect_out(1'b0, 1'b0);
         end
      end
      axi_write(4'h8, 32'h1, 2'h2);
      axi_read(4'hc, 32'h0, 2'h2);
      {bus_width_select, processing_master_enable, standard_mode_pin_in, asi_mode_select} <= 4'he;
      repeat (6) @(posedge aclk);
      axi_read(4'h4, {18'h0, 6'h33, 8'h33}, 2'h0);
      auto_manual_select <= 1'b1;
      core_smpte_locked <= 1'b1;
      core_rate_sd <= 1'b0;
      expect_out(1'b0, 1'b0);
      core_smpte_locked <= 1'b0;
      core_rate_sd <= 1'b1;
      expect_out(1'b0, 1'b0);
      test_port_mode <= 1'b1;
      device_reset_pin_n <= 1'b0;
      expect_out(1'b0, 1'b1);
      device_reset_pin_n <= 1'b1;
      expect_out(1'b0, 1'b0);
      test_port_mode <= 1'b0;
      device_reset_pin_n <= 1'b0;
      expect_out(1'b1, 1'b1);
      device_reset_pin_n <= 1'b1;
      repeat (8) @(posedge aclk);
      axi_read(4'h0, 32'h0, 2'h0);
      print_verdict();
   end
endmodule
